// ### rtl/ulp_packet_timing.sv
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ulp_packet_timing (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ulp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link side strobes
  input wire logic tx_cmd,
  input wire logic tx_sof,
  input wire logic stp,
  // Sensed bus line state, asynchronous
  input wire logic [1:0] line_state,
  // Receive command report
  output logic rxcmd_valid,
  output logic [1:0] rxcmd_line,
  // Transmit status and bus drive
  output logic tx_active,
  output logic tx_busy,
  output logic bus_oe,
  output logic [1:0] drv_line,
  output logic low_power
);

  ulp_pkg::ulp_state_type st_reg;
  ulp_pkg::ulp_state_type st_next;
  logic cmd_ok; // Transmit command accepted this cycle
  logic host_mode; // Both pull-downs set marks a host
  logic ls_chg; // New line state seen; restarts the report delay and feeds the checks

  // Cycles minus one as a loadable count
  function automatic logic [ulp_pkg::CNT_W-1:0] load(input int cyc);
    load = ulp_pkg::CNT_W'(cyc - 1);
  endfunction
  // Whole cycles a bit-timed state is held; one less would cut a bit short
  function automatic logic [ulp_pkg::CNT_W-1:0] span(input int cyc);
    span = ulp_pkg::CNT_W'(cyc);
  endfunction

  // Countdown finished when at one or below
  function automatic logic cnt_done(input logic [ulp_pkg::CNT_W-1:0] c);
    cnt_done = (c <= ulp_pkg::CNT_W'(1));
  endfunction

  // Report delay for a new line state
  function automatic int rx_delay(input logic [1:0] spd, input logic [1:0] ls);
    if (ls != ulp_pkg::LINE_SE0) begin
      rx_delay = ulp_pkg::RX_JK_DLY;
    end else if (spd == ulp_pkg::SPD_HS) begin
      rx_delay = ulp_pkg::RX_SE0_HS;
    end else if (spd == ulp_pkg::SPD_LS) begin
      rx_delay = ulp_pkg::RX_SE0_LS;
    end else begin
      // Preamble receives as full-speed; low-speed traffic still reported
      rx_delay = ulp_pkg::RX_SE0_FS;
    end
  endfunction

  // Start delay per speed
  function automatic int tx_start(input logic [1:0] spd);
    if (spd == ulp_pkg::SPD_HS) begin
      tx_start = ulp_pkg::TX_START_HS;
    end else if (spd == ulp_pkg::SPD_LS) begin
      tx_start = ulp_pkg::TX_START_LS;
    end else begin
      tx_start = ulp_pkg::TX_START_FS;
    end
  endfunction

  assign cmd_ok = tx_cmd && (st_reg.tx_st == ulp_pkg::TX_IDLE) && !st_reg.ctrl.low_power;
  assign host_mode = st_reg.ctrl.dp_pd && st_reg.ctrl.dm_pd;
  assign ls_chg = (st_reg.ls_sync != st_reg.ls_prev);

  // Next-state logic for the whole block
  always_comb begin
    st_next = st_reg;
    st_next.rxcmd_valid = 1'b0;
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    // Two-flop synchroniser on the sensed line
    st_next.ls_meta = line_state;
    st_next.ls_sync = st_reg.ls_meta;

    // Line state report; a new change restarts the delay
    if (ls_chg) begin
      st_next.ls_prev = st_reg.ls_sync;
      st_next.rx_pend = 1'b1;
      st_next.rx_cnt = load(rx_delay(st_reg.ctrl.speed, st_reg.ls_sync));
    end else if (st_reg.rx_pend) begin
      if (cnt_done(st_reg.rx_cnt)) begin
        st_next.rx_pend = 1'b0;
        st_next.rxcmd_valid = 1'b1;
        st_next.rxcmd_line = st_reg.ls_prev;
      end else begin
        st_next.rx_cnt = st_reg.rx_cnt - 1'b1;
      end
    end

    // Transmit sequencer
    case (st_reg.tx_st)
      ulp_pkg::TX_IDLE: begin
        if (cmd_ok) begin
          st_next.sof = tx_sof;
          if (st_reg.ctrl.speed == ulp_pkg::SPD_PRE) begin
            // Header goes out first at full-speed rate
            st_next.tx_st = ulp_pkg::PRE_HDR;
            st_next.tx_cnt = span(ulp_pkg::PRE_PID_BITS * ulp_pkg::FS_BIT_CYC);
          end else if (st_reg.ctrl.opmode == ulp_pkg::OPM_DRIVE) begin
            st_next.tx_st = ulp_pkg::RES_K;
          end else if (tx_start(st_reg.ctrl.speed) <= 1) begin
            st_next.tx_st = ulp_pkg::TX_BUSY;
          end else begin
            st_next.tx_st = ulp_pkg::TX_WAIT;
            st_next.tx_cnt = load(tx_start(st_reg.ctrl.speed));
          end
        end
      end
      ulp_pkg::TX_WAIT: begin
        if (cnt_done(st_reg.tx_cnt)) begin
          st_next.tx_st = ulp_pkg::TX_BUSY;
        end else begin
          st_next.tx_cnt = st_reg.tx_cnt - 1'b1;
        end
      end
      ulp_pkg::TX_BUSY: begin
        // Packet data until the link stops it
        if (stp) begin
          st_next.tx_st = ulp_pkg::TX_ENDING;
          if (st_reg.ctrl.speed != ulp_pkg::SPD_HS) begin
            st_next.tx_cnt = load(ulp_pkg::TX_END_NA);
          end else if (st_reg.sof) begin
            st_next.tx_cnt = load(ulp_pkg::TX_END_SOF);
          end else begin
            st_next.tx_cnt = load(ulp_pkg::TX_END_PKT);
          end
        end
      end
      ulp_pkg::TX_ENDING: begin
        if (cnt_done(st_reg.tx_cnt)) begin
          st_next.tx_st = ulp_pkg::TX_IDLE;
        end else begin
          st_next.tx_cnt = st_reg.tx_cnt - 1'b1;
        end
      end
      ulp_pkg::PRE_HDR: begin
        if (cnt_done(st_reg.tx_cnt)) begin
          st_next.tx_st = ulp_pkg::PRE_J;
          st_next.tx_cnt = span(ulp_pkg::PRE_J_BITS * ulp_pkg::FS_BIT_CYC);
        end else begin
          st_next.tx_cnt = st_reg.tx_cnt - 1'b1;
        end
      end
      ulp_pkg::PRE_J: begin
        // Released after J; pull-up holds it for the rest of the gap
        if (cnt_done(st_reg.tx_cnt)) begin
          st_next.tx_st = ulp_pkg::PRE_GAP;
          st_next.tx_cnt = span((ulp_pkg::PRE_GAP_BITS - ulp_pkg::PRE_J_BITS)
                                * ulp_pkg::FS_BIT_CYC);
        end else begin
          st_next.tx_cnt = st_reg.tx_cnt - 1'b1;
        end
      end
      ulp_pkg::PRE_GAP: begin
        if (cnt_done(st_reg.tx_cnt)) begin
          st_next.tx_st = ulp_pkg::TX_BUSY;
        end else begin
          st_next.tx_cnt = st_reg.tx_cnt - 1'b1;
        end
      end
      ulp_pkg::RES_K: begin
        // Resume K until STP; only a host appends the end
        if (stp) begin
          if (host_mode) begin
            st_next.tx_st = ulp_pkg::EOP_SE0;
            st_next.tx_cnt = span(ulp_pkg::EOP_SE0_BITS * ulp_pkg::LS_BIT_CYC);
          end else begin
            st_next.tx_st = ulp_pkg::TX_IDLE;
          end
        end
      end
      ulp_pkg::EOP_SE0: begin
        if (cnt_done(st_reg.tx_cnt)) begin
          st_next.tx_st = ulp_pkg::EOP_J;
          st_next.tx_cnt = span(ulp_pkg::EOP_J_BITS * ulp_pkg::LS_BIT_CYC);
        end else begin
          st_next.tx_cnt = st_reg.tx_cnt - 1'b1;
        end
      end
      ulp_pkg::EOP_J: begin
        if (cnt_done(st_reg.tx_cnt)) begin
          st_next.tx_st = ulp_pkg::TX_IDLE;
        end else begin
          st_next.tx_cnt = st_reg.tx_cnt - 1'b1;
        end
      end
      default: begin
        st_next.tx_st = ulp_pkg::TX_IDLE;
      end
    endcase

    // Outputs follow the next state so they leave a flop
    st_next.tx_busy = (st_next.tx_st != ulp_pkg::TX_IDLE);
    st_next.tx_active = st_next.tx_st inside {ulp_pkg::TX_BUSY, ulp_pkg::TX_ENDING,
      ulp_pkg::PRE_HDR, ulp_pkg::PRE_J, ulp_pkg::PRE_GAP};
    st_next.bus_oe = st_next.tx_st inside {ulp_pkg::TX_BUSY, ulp_pkg::TX_ENDING,
      ulp_pkg::PRE_HDR, ulp_pkg::PRE_J, ulp_pkg::RES_K, ulp_pkg::EOP_SE0, ulp_pkg::EOP_J};
    case (st_next.tx_st)
      ulp_pkg::PRE_J: st_next.drv_line = ulp_pkg::LINE_J;
      ulp_pkg::EOP_J: st_next.drv_line = ulp_pkg::LINE_J;
      ulp_pkg::RES_K: st_next.drv_line = ulp_pkg::LINE_K;
      ulp_pkg::EOP_SE0: st_next.drv_line = ulp_pkg::LINE_SE0;
      default: st_next.drv_line = ulp_pkg::LINE_DATA;
    endcase

    // APB: answer in the access phase, no wait states
    if (psel && !penable) begin
      st_next.pready = 1'b1;
      if (paddr == ulp_pkg::CTRL_ADDR) begin
        st_next.prdata = 32'(st_reg.ctrl);
      end else if (paddr == ulp_pkg::STAT_ADDR) begin
        st_next.prdata = 32'(ulp_pkg::ulp_stat_type'({st_reg.rx_pend, st_reg.ls_prev,
          st_reg.ctrl.low_power, st_reg.tx_busy}));
      end else begin
        st_next.prdata = 32'h0000_0000;
        st_next.pslverr = 1'b1;
      end
    end
    // Write lands on the completing access edge only
    if (psel && penable && st_reg.pready && pwrite && (paddr == ulp_pkg::CTRL_ADDR)) begin
      st_next.ctrl = ulp_pkg::ulp_ctrl_type'(pwdata[$bits(ulp_pkg::ulp_ctrl_type)-1:0]);
    end
    // STP wakes the transceiver; hardware clear follows any write
    if (stp && st_reg.ctrl.low_power) begin
      st_next.ctrl.low_power = 1'b0;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flops
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign rxcmd_valid = st_reg.rxcmd_valid;
  assign rxcmd_line = st_reg.rxcmd_line;
  assign tx_active = st_reg.tx_active;
  assign tx_busy = st_reg.tx_busy;
  assign bus_oe = st_reg.bus_oe;
  assign drv_line = st_reg.drv_line;
  assign low_power = st_reg.ctrl.low_power;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_jk_settled;
    (ls_chg && st_reg.ls_sync != ulp_pkg::LINE_SE0) ##1 (!ls_chg)[*3];
  endsequence
  sequence s_resume_stop;
    (st_reg.tx_st == ulp_pkg::RES_K) && stp;
  endsequence
  sequence s_pre_hdr_done;
    (st_reg.tx_st == ulp_pkg::PRE_HDR) ##1 (st_reg.tx_st == ulp_pkg::PRE_J);
  endsequence

  a_jk_report_delay: assert property (s_jk_settled |=> rxcmd_valid && rxcmd_line != 2'h0)
    else $error("J/K report not four clocks after change");
  a_se0_ls_delay: assert property (
    (rxcmd_valid && rxcmd_line == ulp_pkg::LINE_SE0 && st_reg.ctrl.speed == ulp_pkg::SPD_LS)
    |-> $past(ls_chg, 16))
    else $error("Low-speed SE0 report not sixteen clocks after change");
  a_tx_start_hs: assert property ((cmd_ok && st_reg.ctrl.speed == ulp_pkg::SPD_HS
    && st_reg.ctrl.opmode != ulp_pkg::OPM_DRIVE) |=> tx_active)
    else $error("High-speed transmit did not start in one clock");
  a_tx_start_fs: assert property ((cmd_ok && st_reg.ctrl.speed == ulp_pkg::SPD_FS
    && st_reg.ctrl.opmode != ulp_pkg::OPM_DRIVE) |=> (!tx_active)[*5] ##1 tx_active)
    else $error("Full-speed transmit start not six clocks");
  a_tx_end_hs: assert property ((st_reg.tx_st == ulp_pkg::TX_BUSY && stp && !st_reg.sof
    && st_reg.ctrl.speed == ulp_pkg::SPD_HS) |=> tx_active[*2] ##1 !tx_active)
    else $error("High-speed packet end not three clocks");
  a_pre_header_out: assert property ((cmd_ok && st_reg.ctrl.speed == ulp_pkg::SPD_PRE)
    |=> (bus_oe && drv_line == ulp_pkg::LINE_DATA)[*8])
    else $error("Preamble header not sent first");
  a_pre_j_drive: assert property (s_pre_hdr_done |-> (bus_oe && drv_line == ulp_pkg::LINE_J)[*8])
    else $error("J not driven after preamble header");
  a_pre_gap_release: assert property ((st_reg.tx_st == ulp_pkg::PRE_J ##1
    st_reg.tx_st == ulp_pkg::PRE_GAP) |-> (!bus_oe)[*8])
    else $error("Bus not released during preamble gap");
  a_resume_eop: assert property ((s_resume_stop ##0 host_mode)
    |=> (bus_oe && drv_line == ulp_pkg::LINE_SE0)[*8])
    else $error("Resume end not started with SE0");
  a_eop_host_only: assert property ((s_resume_stop ##0 !host_mode) |=> !bus_oe)
    else $error("Resume end added without host pull-downs");

endmodule
`default_nettype wire

// ### rtl/ulp_pkg.sv
`default_nettype none
package ulp_pkg;
  // Transceiver speed select codes
  localparam logic [1:0] SPD_HS = 2'h0;
  localparam logic [1:0] SPD_FS = 2'h1;
  localparam logic [1:0] SPD_LS = 2'h2;
  localparam logic [1:0] SPD_PRE = 2'h3;
  // Operating mode that drives K for resume
  localparam logic [1:0] OPM_DRIVE = 2'h2;
  // Line codes, for sensed state and for the driven level
  localparam logic [1:0] LINE_SE0 = 2'h0;
  localparam logic [1:0] LINE_J = 2'h1;
  localparam logic [1:0] LINE_K = 2'h2;
  localparam logic [1:0] LINE_DATA = 2'h3;
  // Pipeline delays in interface clocks
  localparam int RX_JK_DLY = 4;
  localparam int RX_SE0_HS = 4;
  localparam int RX_SE0_FS = 4;
  localparam int RX_SE0_LS = 16;
  localparam int TX_START_HS = 1;
  localparam int TX_START_FS = 6;
  localparam int TX_START_LS = 74;
  localparam int TX_END_PKT = 3;
  localparam int TX_END_SOF = 6;
  localparam int TX_END_NA = 1;
  // Bit times derived from the clock rate, rounded up
  localparam int CLK_HZ = 200_000_000;
  localparam int FS_RATE_HZ = 12_000_000;
  localparam int LS_RATE_HZ = 1_500_000;
  localparam int FS_BIT_CYC = (CLK_HZ + FS_RATE_HZ - 1) / FS_RATE_HZ;
  localparam int LS_BIT_CYC = (CLK_HZ + LS_RATE_HZ - 1) / LS_RATE_HZ;
  // Preamble and resume end-of-packet lengths in bits
  localparam int PRE_PID_BITS = 16;
  localparam int PRE_J_BITS = 1;
  localparam int PRE_GAP_BITS = 4;
  localparam int EOP_SE0_BITS = 2;
  localparam int EOP_J_BITS = 1;
  localparam int CNT_W = 10;
  // Register map
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 12'h004;

  // Control register layout, low bit last
  typedef struct packed {
    logic low_power;
    logic dm_pd;
    logic dp_pd;
    logic [1:0] opmode;
    logic [1:0] speed;
  } ulp_ctrl_type;
  localparam ulp_ctrl_type CTRL_RST = 7'h00;

  // Status register layout
  typedef struct packed {
    logic rx_pend;
    logic [1:0] line;
    logic low_power;
    logic tx_busy;
  } ulp_stat_type;

  typedef enum logic [3:0] {
    TX_IDLE, TX_WAIT, TX_BUSY, TX_ENDING, PRE_HDR, PRE_J, PRE_GAP,
    RES_K, EOP_SE0, EOP_J
  } ulp_tx_state_type;

  // Whole state of the block
  typedef struct packed {
    ulp_ctrl_type ctrl;
    logic [1:0] ls_meta;
    logic [1:0] ls_sync;
    logic [1:0] ls_prev;
    logic rx_pend;
    logic [CNT_W-1:0] rx_cnt;
    ulp_tx_state_type tx_st;
    logic [CNT_W-1:0] tx_cnt;
    logic sof;
    logic rxcmd_valid;
    logic [1:0] rxcmd_line;
    logic tx_active;
    logic bus_oe;
    logic [1:0] drv_line;
    logic tx_busy;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ulp_state_type;
endpackage
`default_nettype wire

// ### test/ulp_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module ulp_link_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Line reports from the block
  input wire logic rxcmd_valid,
  input wire logic [1:0] rxcmd_line,
  // Link strobes and sensed bus line
  output logic tx_cmd,
  output logic tx_sof,
  output logic stp,
  output logic [1:0] line_state
);
  // Interface clocks since the last packet end marker, also the response wait
  int since;
  // Last reported line state
  logic [1:0] last_line;

  // Quiet link at time zero
  initial begin
    tx_cmd = 1'b0;
    tx_sof = 1'b0;
    stp = 1'b0;
    line_state = ulp_pkg::LINE_SE0;
    last_line = ulp_pkg::LINE_SE0;
    since = 0;
  end

  // Gap counter restarts at the end of a packet
  always @(posedge pclk) begin
    since <= since + 1;
    if (stp) begin
      since <= 0;
    end
    if (rxcmd_valid) begin
      last_line <= rxcmd_line;
      if (last_line === ulp_pkg::LINE_SE0 && rxcmd_line === ulp_pkg::LINE_J) begin
        since <= 0;
      end
    end
  end

  // Transmit command after the decision gap has run out
  task automatic send(input logic sof, input int gap);
    @(posedge pclk);
    while (since < gap) begin
      @(posedge pclk);
    end
    tx_cmd <= 1'b1;
    tx_sof <= sof;
    @(posedge pclk);
    tx_cmd <= 1'b0;
    tx_sof <= 1'b0;
  endtask

  // One-cycle stop pulse, also wakes from low power
  task automatic stop();
    @(posedge pclk);
    stp <= 1'b1;
    @(posedge pclk);
    stp <= 1'b0;
  endtask

  // New bus level seen by the block
  task automatic drive_line(input logic [1:0] v);
    @(posedge pclk);
    line_state <= v;
  endtask
endmodule
`default_nettype wire

// ### test/ulp_packet_timing_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ulp_packet_timing_tb;
  // APB master side
  logic pclk, presetn, psel, penable, pwrite;
  logic [ulp_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er;
  // Link side and observed outputs
  wire logic tx_cmd, tx_sof, stp, rxcmd_valid, tx_active, tx_busy, bus_oe, low_power;
  wire logic [1:0] line_state, rxcmd_line, drv_line;
  // Watched events, indexed by cyc_until
  wire logic [7:0] ev;
  int errors, tests_run, n, m;
  // Per-speed figures: HS, FS, LS
  int se0_lo[3] = '{4, 4, 16};
  int se0_hi[3] = '{4, 6, 18};
  int st_lo[3] = '{1, 6, 74};
  int st_hi[3] = '{2, 10, 75};
  int gap[3] = '{15, 7, 77};

  assign ev = {bus_oe, tx_busy, bus_oe & (drv_line == ulp_pkg::LINE_SE0),
    bus_oe & (drv_line == ulp_pkg::LINE_K), bus_oe & (drv_line == ulp_pkg::LINE_J),
    bus_oe & (drv_line == ulp_pkg::LINE_DATA), tx_active, rxcmd_valid};

  ulp_packet_timing DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_cmd(tx_cmd), .tx_sof(tx_sof), .stp(stp),
    .line_state(line_state), .rxcmd_valid(rxcmd_valid), .rxcmd_line(rxcmd_line),
    .tx_active(tx_active), .tx_busy(tx_busy), .bus_oe(bus_oe), .drv_line(drv_line),
    .low_power(low_power));

  ulp_link_model link (.pclk(pclk), .presetn(presetn), .rxcmd_valid(rxcmd_valid),
    .rxcmd_line(rxcmd_line), .tx_cmd(tx_cmd), .tx_sof(tx_sof), .stp(stp),
    .line_state(line_state));

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Value compare
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Cycle count compare against a window
  task automatic check_rng(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  // One APB transfer; request held until pready seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait-state count assumed; the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Count settled cycles until an event reaches a level; n is the last
  // edge before it shows, so the level is first sampled at edge n + 1
  task automatic cyc_until(input int i, input logic v);
    n = 0;
    #1;
    while (ev[i] !== v && n < 2000) begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (ev[i] !== v) check_val(ev[i], v);
  endtask

  // Verdict, reached from the tests and the watchdog
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard, well beyond the thousand or so cycles needed
  initial begin
    repeat (50000) @(posedge pclk);
    errors++;
    end_sim();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    errors = 0;
    tests_run = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Reset value, unmapped place, reserved bits, low power
    apb(1'b0, ulp_pkg::CTRL_ADDR, 32'h0);
    check_val(rd, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    check_val(er, 32'h1);
    apb(1'b1, ulp_pkg::CTRL_ADDR, 32'hFFFF_FFC1);
    apb(1'b0, ulp_pkg::CTRL_ADDR, 32'h0);
    check_val(rd, 32'h41);
    apb(1'b0, ulp_pkg::STAT_ADDR, 32'h0);
    check_val(rd[1], 32'h1);
    link.send(1'b0, 0);
    repeat (20) @(posedge pclk);
    check_val(tx_busy, 32'h0);
    link.stop();
    repeat (2) @(posedge pclk);
    check_val(low_power, 32'h0);
    $display("test registers done");
    // Line reports and transmit timing at each speed
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, ulp_pkg::CTRL_ADDR, s);
      link.drive_line(ulp_pkg::LINE_J);
      cyc_until(0, 1'b1);
      check_rng(n, 6, 6);
      check_val(rxcmd_line, ulp_pkg::LINE_J);
      link.drive_line(ulp_pkg::LINE_SE0);
      cyc_until(0, 1'b1);
      check_rng(n, se0_lo[s] + 2, se0_hi[s] + 2);
      link.send(1'b0, gap[s]);
      cyc_until(1, 1'b1);
      check_rng(n + 1, st_lo[s], st_hi[s]);
      link.stop();
      cyc_until(1, 1'b0);
      if (s == 0) check_rng(n + 1, 3, 4);
    end
    apb(1'b1, ulp_pkg::CTRL_ADDR, 32'h0);
    link.send(1'b1, 15);
    cyc_until(1, 1'b1);
    link.stop();
    cyc_until(1, 1'b0);
    check_rng(n + 1, 6, 9);
    $display("test timing done");
    // Preamble header, J hold, release gap
    apb(1'b1, ulp_pkg::CTRL_ADDR, ulp_pkg::SPD_PRE);
    link.drive_line(ulp_pkg::LINE_K);
    cyc_until(0, 1'b1);
    check_rng(n, 6, 6);
    link.send(1'b0, 7);
    cyc_until(2, 1'b1);
    cyc_until(3, 1'b1);
    check_rng(n, ulp_pkg::PRE_PID_BITS * ulp_pkg::FS_BIT_CYC, 1999);
    cyc_until(3, 1'b0);
    m = n;
    check_rng(m, ulp_pkg::FS_BIT_CYC, 1999);
    check_val(bus_oe, 32'h0);
    cyc_until(2, 1'b1);
    check_rng(m + n, 4 * ulp_pkg::FS_BIT_CYC, 1999);
    link.stop();
    cyc_until(6, 1'b0);
    $display("test preamble done");
    // Resume K, then end of resume with and without pull-downs
    apb(1'b1, ulp_pkg::CTRL_ADDR, 32'h39);
    link.send(1'b0, 0);
    cyc_until(4, 1'b1);
    check_rng(n + 1, 1, 2);
    link.stop();
    cyc_until(5, 1'b1);
    cyc_until(5, 1'b0);
    check_rng(n, 2 * ulp_pkg::LS_BIT_CYC, 2 * ulp_pkg::LS_BIT_CYC + 1);
    check_val(ev[3], 32'h1);
    cyc_until(3, 1'b0);
    check_rng(n, ulp_pkg::LS_BIT_CYC, ulp_pkg::LS_BIT_CYC + 1);
    apb(1'b1, ulp_pkg::CTRL_ADDR, 32'h09);
    link.send(1'b0, 0);
    cyc_until(4, 1'b1);
    link.stop();
    cyc_until(7, 1'b0);
    check_rng(n + 1, 1, 2);
    apb(1'b1, ulp_pkg::CTRL_ADDR, 32'h0);
    $display("test resume done");
    end_sim();
  end
endmodule
`default_nettype wire
